// *** rtl/rsv_pkg.sv ***
// Constants and types for the reservation and registration block.
// Assumes one 25 MHz clock and a 32-bit Avalon-MM register bus with byte addresses.
package rsv_pkg;
    localparam int NS_N  = 4;
    localparam int HOST_N = 4;
    localparam int NS_W  = 2;
    localparam int HID_W = 2;
    localparam int ENT_N = NS_N * HOST_N;
    localparam int ENT_W = NS_W + HID_W;
    localparam int KEY_W = 64;

    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_IDCTL    = 8'h04;
    localparam logic [7:0] OFS_NSCAP    = 8'h08;
    localparam logic [7:0] OFS_HOSTID   = 8'h0C;
    localparam logic [7:0] OFS_CMD      = 8'h10;
    localparam logic [7:0] OFS_STAT     = 8'h14;
    localparam logic [7:0] OFS_CURRENT_KEY_FIELD_LO = 8'h18;
    localparam logic [7:0] OFS_CURRENT_KEY_FIELD_HI = 8'h1C;
    localparam logic [7:0] OFS_NEW_KEY_FIELD_LO = 8'h20;
    localparam logic [7:0] OFS_NEW_KEY_FIELD_HI = 8'h24;
    localparam logic [7:0] OFS_HOLD     = 8'h28;
    localparam logic [7:0] OFS_NMASK    = 8'h2C;
    localparam logic [7:0] OFS_NTFY     = 8'h30;
    localparam logic [7:0] OFS_LOG      = 8'h34;
    localparam logic [7:0] OFS_REGMAP   = 8'h38;
    localparam logic [7:0] OFS_IDNS     = 8'h3C;

    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_ACT_LSB  = 3;
    localparam int CMD_IGNORE_EXISTING_KEY_BIT    = 6;
    localparam int CMD_NS_LSB   = 7;
    localparam int CMD_CTRL_LSB = 9;
    localparam int OPTIONAL_COMMAND_SUPPORT_FIELD_RSV_BIT = 5;
    localparam int NSCAP_POWER_LOSS_PERSIST_STATE_LSB = 4;
    localparam int NTFY_NS_LSB  = 2;

    localparam logic       CTRL_RST   = 1'b1;
    localparam logic [3:0] NSCAP_RST  = 4'hF;
    localparam logic [7:0] HOSTID_RST = 8'hE4;
    localparam logic [7:0] RESERVATION_CAPABILITY_FIELD_VAL = 8'h01;

    localparam logic [2:0] ACT_REGISTER = 3'h0;
    localparam logic [2:0] ACT_UNREG    = 3'h1;
    localparam logic [2:0] ACT_REPLACE  = 3'h2;

    localparam logic [1:0] SC_OK        = 2'h0;
    localparam logic [1:0] SC_BAD_OPC   = 2'h1;
    localparam logic [1:0] SC_CONFLICT  = 2'h2;
    localparam logic [1:0] SC_BAD_FIELD = 2'h3;

    localparam logic [1:0] NTF_REG_PREEMPT = 2'h1;
    localparam logic [1:0] NTF_RSV_RELEASE = 2'h2;
    localparam logic [1:0] NTF_RSV_PREEMPT = 2'h3;

    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_REPORT, OP_REGISTER, OP_ACQUIRE, OP_RELEASE, OP_OTHER
    } rsv_op_t;
endpackage

// *** rtl/rsv_tab_if.sv ***
// Link between the command logic and the shared registrant table.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface rsv_tab_if;
    logic [rsv_pkg::NS_W-1:0]  ns;
    logic [rsv_pkg::HID_W-1:0] host;
    logic                      rd_valid;
    logic [rsv_pkg::KEY_W-1:0] rd_key;
    logic                      wr_en;
    logic                      wr_valid;
    logic [rsv_pkg::KEY_W-1:0] wr_key;
    logic [rsv_pkg::ENT_N-1:0] vld_all;
    modport ctl (output ns, host, wr_en, wr_valid, wr_key, input rd_valid, rd_key, vld_all);
    modport tab (input ns, host, wr_en, wr_valid, wr_key, output rd_valid, rd_key, vld_all);
endinterface
`default_nettype wire

// *** rtl/rsv_regtab.sv ***
// Registrant table: one entry per namespace and host identifier.
// Assumes the command logic addresses it with a stable namespace and host.
`timescale 1ns/100ps
`default_nettype none
module rsv_regtab (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic ce,
    rsv_tab_if.tab    t
);
    logic                      vld_q [rsv_pkg::ENT_N];
    logic [rsv_pkg::KEY_W-1:0] key_q [rsv_pkg::ENT_N];
    logic [rsv_pkg::ENT_W-1:0] idx;

    assign idx = {t.ns, t.host};
    assign t.rd_valid = vld_q[idx];
    assign t.rd_key = key_q[idx];

    // Indexing by host identifier gives every controller of a host the same entry.
    for (genvar e = 0; e < rsv_pkg::ENT_N; e++) begin : g_ent
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                vld_q[e] <= 1'b0;
                key_q[e] <= '0;
            end else if (ce && t.wr_en && idx == rsv_pkg::ENT_W'(e)) begin
                vld_q[e] <= t.wr_valid;
                key_q[e] <= t.wr_key;
            end
        end
        assign t.vld_all[e] = vld_q[e];
    end
endmodule
`default_nettype wire

// *** rtl/rsv_top.sv ***
// Reservation command checking, registrant bookkeeping and notification log.
// Assumes an Avalon-MM master with waitrequest on clk_sys and a synchronous reset.
//
// Notes on behaviour
// - Commands lacking rights under a reservation conflict.
// - Reservation commands without support: invalid opcode.
// - Identify-controller bit 5 shows reservation support.
// - Supporting namespace reports nonzero capability, persist state.
// - Table holds an entry for every host.
// - One support bit serves all controllers.
// - Register action 000b records the host.
// - Register action 000b ignores the ignore-key bit.
// - Registrant registering a different key conflicts.
// - Re-registering the same key succeeds.
// - Equal keys across hosts never conflict.
// - Registration is seen by all host's controllers.
// - Action 010b replaces current key with new.
// - Replace updates key for all host's controllers.
// - Replace with mismatched current key conflicts.
// - Ignore-key bit forces replace unconditionally.
// - Key change leaves reservation untouched.
// - Three notification kinds are distinguished.
// - Unmasked notification logs entry, raises event.
// - Mask per notification kind and namespace.
// - Rights depend on host identifier only.
// - Unregister 001b checks registrant and key.
`timescale 1ns/100ps
`default_nettype none
module rsv_top (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             rsv_log_avail
);
    typedef enum logic {RSV_IDLE, RSV_EVAL} rsv_state_t;

    rsv_tab_if tab_if ();

    rsv_regtab u_tab (
        .clk_sys (clk_sys),
        .srst    (srst),
        .ce      (ce),
        .t       (tab_if.tab)
    );

    logic                       wait_q;
    logic [31:0]                rdata_q;
    logic [31:0]                rdata_d;
    logic                       ctl_q;
    logic [3:0]                 nscap_q;
    logic [3:0]                 power_loss_persist_state_q;
    logic [7:0]                 hostid_q;
    logic [rsv_pkg::KEY_W-1:0]  current_key_field_q;
    logic [rsv_pkg::KEY_W-1:0]  new_key_field_q;
    logic [15:0]                hold_q;
    logic [11:0]                nmask_q;
    logic                       log_pend_q;
    logic [1:0]                 log_kind_q;
    logic [1:0]                 log_ns_q;
    logic [7:0]                 log_lost_q;
    rsv_state_t                 state_q;
    rsv_pkg::rsv_op_t           op_q;
    logic [2:0]                 act_q;
    logic                       ignore_existing_key_bit_q;
    logic [1:0]                 ns_q;
    logic [1:0]                 ctrl_q;
    logic [1:0]                 stat_q;
    logic [1:0]                 stat_d;
    logic                       done_q;
    logic                       wr_acc;
    logic                       rd_acc;
    logic                       launch;
    logic                       supp;
    logic                       rsv_op;
    logic [1:0]                 host;
    logic                       held;
    logic                       excl;
    logic [1:0]                 holder;
    logic                       twr;
    logic                       tvalid;
    logic [rsv_pkg::KEY_W-1:0]  tkey;
    logic [1:0]                 ntf_kind;
    logic [1:0]                 ntf_ns;
    logic [rsv_pkg::NS_N-1:0]   ntf_live;
    logic [31:0]                reservation_capability_field_all;
    logic                       ntf_set;
    logic                       log_clr;

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign rsv_log_avail = log_pend_q;

    // The access completes on the second edge of a request.
    assign wr_acc = avs_write & ~wait_q;
    assign rd_acc = avs_read & ~wait_q;
    assign launch = wr_acc && avs_address == rsv_pkg::OFS_CMD && state_q == RSV_IDLE;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wait_q <= 1'b1;
        end else if (ce) begin
            wait_q <= ~((avs_read | avs_write) & wait_q);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_q <= '0;
        end else if (ce && (avs_read & wait_q)) begin
            rdata_q <= rdata_d;
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctl_q    <= rsv_pkg::CTRL_RST;
            nscap_q  <= rsv_pkg::NSCAP_RST;
            power_loss_persist_state_q   <= '0;
            hostid_q <= rsv_pkg::HOSTID_RST;
            current_key_field_q  <= '0;
            new_key_field_q  <= '0;
            hold_q   <= '0;
            nmask_q  <= '0;
        end else if (ce && wr_acc) begin
            case (avs_address)
                rsv_pkg::OFS_CTRL: begin
                    ctl_q <= avs_writedata[0];
                end
                rsv_pkg::OFS_NSCAP: begin
                    nscap_q <= avs_writedata[3:0];
                    // Persist state exists only where the namespace supports reservations.
                    power_loss_persist_state_q <= avs_writedata[rsv_pkg::NSCAP_POWER_LOSS_PERSIST_STATE_LSB +: 4] & avs_writedata[3:0];
                end
                rsv_pkg::OFS_HOSTID: begin
                    hostid_q <= avs_writedata[7:0];
                end
                rsv_pkg::OFS_CURRENT_KEY_FIELD_LO: begin
                    current_key_field_q[31:0] <= avs_writedata;
                end
                rsv_pkg::OFS_CURRENT_KEY_FIELD_HI: begin
                    current_key_field_q[63:32] <= avs_writedata;
                end
                rsv_pkg::OFS_NEW_KEY_FIELD_LO: begin
                    new_key_field_q[31:0] <= avs_writedata;
                end
                rsv_pkg::OFS_NEW_KEY_FIELD_HI: begin
                    new_key_field_q[63:32] <= avs_writedata;
                end
                rsv_pkg::OFS_HOLD: begin
                    hold_q <= avs_writedata[15:0];
                end
                rsv_pkg::OFS_NMASK: begin
                    nmask_q <= avs_writedata[11:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Command capture and one evaluation cycle.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= RSV_IDLE;
            op_q    <= rsv_pkg::OP_OTHER;
            act_q   <= '0;
            ignore_existing_key_bit_q <= 1'b0;
            ns_q    <= '0;
            ctrl_q  <= '0;
            stat_q  <= rsv_pkg::SC_OK;
            done_q  <= 1'b0;
        end else if (ce) begin
            case (state_q)
                RSV_IDLE: begin
                    if (launch) begin
                        op_q    <= rsv_pkg::rsv_op_t'(avs_writedata[rsv_pkg::CMD_OP_LSB +: 3]);
                        act_q   <= avs_writedata[rsv_pkg::CMD_ACT_LSB +: 3];
                        ignore_existing_key_bit_q <= avs_writedata[rsv_pkg::CMD_IGNORE_EXISTING_KEY_BIT];
                        ns_q    <= avs_writedata[rsv_pkg::CMD_NS_LSB +: 2];
                        ctrl_q  <= avs_writedata[rsv_pkg::CMD_CTRL_LSB +: 2];
                        done_q  <= 1'b0;
                        state_q <= RSV_EVAL;
                    end
                end
                RSV_EVAL: begin
                    stat_q  <= stat_d;
                    done_q  <= 1'b1;
                    state_q <= RSV_IDLE;
                end
                default: begin
                    state_q <= RSV_IDLE;
                end
            endcase
        end
    end

    // Rights follow the host identifier, never the controller that carried the command.
    assign host   = hostid_q[ctrl_q*2 +: 2];
    assign supp   = ctl_q & nscap_q[ns_q];
    assign rsv_op = op_q == rsv_pkg::OP_REPORT || op_q == rsv_pkg::OP_REGISTER
                 || op_q == rsv_pkg::OP_ACQUIRE || op_q == rsv_pkg::OP_RELEASE;
    assign held   = hold_q[ns_q*4];
    assign excl   = hold_q[ns_q*4 + 1];
    assign holder = hold_q[ns_q*4 + 2 +: 2];

    always_comb begin
        stat_d = rsv_pkg::SC_OK;
        twr    = 1'b0;
        tvalid = tab_if.rd_valid;
        tkey   = tab_if.rd_key;
        if (rsv_op && !supp) begin
            stat_d = rsv_pkg::SC_BAD_OPC;
        end else if (op_q == rsv_pkg::OP_REGISTER) begin
            case (act_q)
                rsv_pkg::ACT_REGISTER: begin
                    // The ignore-key bit plays no part here; keys of other hosts are not consulted.
                    if (tab_if.rd_valid && tab_if.rd_key != new_key_field_q) begin
                        stat_d = rsv_pkg::SC_CONFLICT;
                    end else begin
                        twr    = 1'b1;
                        tvalid = 1'b1;
                        tkey   = new_key_field_q;
                    end
                end
                rsv_pkg::ACT_UNREG: begin
                    if (!tab_if.rd_valid || (!ignore_existing_key_bit_q && tab_if.rd_key != current_key_field_q)) begin
                        stat_d = rsv_pkg::SC_CONFLICT;
                    end else begin
                        twr    = 1'b1;
                        tvalid = 1'b0;
                    end
                end
                rsv_pkg::ACT_REPLACE: begin
                    if (!ignore_existing_key_bit_q && (!tab_if.rd_valid || tab_if.rd_key != current_key_field_q)) begin
                        stat_d = rsv_pkg::SC_CONFLICT;
                    end else begin
                        // Only the table changes; the holder register is left alone.
                        twr    = 1'b1;
                        tvalid = 1'b1;
                        tkey   = new_key_field_q;
                    end
                end
                default: begin
                    stat_d = rsv_pkg::SC_BAD_FIELD;
                end
            endcase
        end else if (held && host != holder) begin
            if (op_q == rsv_pkg::OP_WRITE || (op_q == rsv_pkg::OP_READ && excl)) begin
                stat_d = rsv_pkg::SC_CONFLICT;
            end
        end
    end

    // One entry per host identifier, so a register command never lacks room.
    assign tab_if.ns       = ns_q;
    assign tab_if.host     = host;
    assign tab_if.wr_en    = state_q == RSV_EVAL && twr;
    assign tab_if.wr_valid = tvalid;
    assign tab_if.wr_key   = tkey;

    // Notification injection, masking and the single-entry log.
    assign ntf_kind = avs_writedata[1:0];
    assign ntf_ns   = avs_writedata[rsv_pkg::NTFY_NS_LSB +: 2];
    for (genvar n = 0; n < rsv_pkg::NS_N; n++) begin : g_ns
        assign ntf_live[n] = (ntf_kind == rsv_pkg::NTF_REG_PREEMPT && !nmask_q[n*3])
                          || (ntf_kind == rsv_pkg::NTF_RSV_RELEASE && !nmask_q[n*3 + 1])
                          || (ntf_kind == rsv_pkg::NTF_RSV_PREEMPT && !nmask_q[n*3 + 2]);
        assign reservation_capability_field_all[n*8 +: 8] = nscap_q[n] ? rsv_pkg::RESERVATION_CAPABILITY_FIELD_VAL : 8'h00;
    end
    assign ntf_set = wr_acc && avs_address == rsv_pkg::OFS_NTFY && ntf_live[ntf_ns];
    assign log_clr = rd_acc && avs_address == rsv_pkg::OFS_LOG;

    // A new entry in the clearing cycle wins over the clear.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            log_pend_q <= 1'b0;
            log_kind_q <= '0;
            log_ns_q   <= '0;
            log_lost_q <= '0;
        end else if (ce) begin
            if (ntf_set) begin
                log_pend_q <= 1'b1;
                log_kind_q <= ntf_kind;
                log_ns_q   <= ntf_ns;
                if (log_pend_q && !log_clr && log_lost_q != 8'hFF) begin
                    log_lost_q <= log_lost_q + 8'h01;
                end
            end else if (log_clr) begin
                log_pend_q <= 1'b0;
                log_lost_q <= '0;
            end
        end
    end

    always_comb begin
        rdata_d = '0;
        case (avs_address)
            rsv_pkg::OFS_CTRL:     rdata_d[0] = ctl_q;
            rsv_pkg::OFS_IDCTL:    rdata_d[rsv_pkg::OPTIONAL_COMMAND_SUPPORT_FIELD_RSV_BIT] = ctl_q;
            rsv_pkg::OFS_NSCAP:    rdata_d[7:0] = {power_loss_persist_state_q, nscap_q};
            rsv_pkg::OFS_HOSTID:   rdata_d[7:0] = hostid_q;
            rsv_pkg::OFS_STAT:     rdata_d[3:0] = {done_q, stat_q, state_q != RSV_IDLE};
            rsv_pkg::OFS_CURRENT_KEY_FIELD_LO: rdata_d = current_key_field_q[31:0];
            rsv_pkg::OFS_CURRENT_KEY_FIELD_HI: rdata_d = current_key_field_q[63:32];
            rsv_pkg::OFS_NEW_KEY_FIELD_LO: rdata_d = new_key_field_q[31:0];
            rsv_pkg::OFS_NEW_KEY_FIELD_HI: rdata_d = new_key_field_q[63:32];
            rsv_pkg::OFS_HOLD:     rdata_d[15:0] = hold_q;
            rsv_pkg::OFS_NMASK:    rdata_d[11:0] = nmask_q;
            rsv_pkg::OFS_LOG:      rdata_d[15:0] = {log_lost_q, 3'h0, log_ns_q, log_kind_q, log_pend_q};
            rsv_pkg::OFS_REGMAP:   rdata_d[15:0] = tab_if.vld_all;
            rsv_pkg::OFS_IDNS:     rdata_d = reservation_capability_field_all;
            default:               rdata_d = '0;
        endcase
    end

    a_optional_command_support_field_bit: assert property (@(posedge clk_sys) disable iff (srst)
        (avs_read && !avs_waitrequest && avs_address == rsv_pkg::OFS_IDCTL)
        |-> avs_readdata[rsv_pkg::OPTIONAL_COMMAND_SUPPORT_FIELD_RSV_BIT] == ctl_q)
        else $error("Support bit does not follow the support control.");

    a_bad_opcode: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && state_q == RSV_EVAL && rsv_op && !supp)
        |=> stat_q == rsv_pkg::SC_BAD_OPC && done_q)
        else $error("Unsupported reservation command not refused.");

    a_access_conflict: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && state_q == RSV_EVAL && op_q == rsv_pkg::OP_WRITE && held && host != holder)
        |=> stat_q == rsv_pkg::SC_CONFLICT)
        else $error("Write by a non-holder was not refused.");

    a_reg_diffkey: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && state_q == RSV_EVAL && supp && op_q == rsv_pkg::OP_REGISTER
         && act_q == rsv_pkg::ACT_REGISTER && tab_if.rd_valid && tab_if.rd_key != new_key_field_q)
        |=> stat_q == rsv_pkg::SC_CONFLICT && $stable(tab_if.rd_key))
        else $error("Different key accepted from a registrant.");

    a_reg_record: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && state_q == RSV_EVAL && supp && op_q == rsv_pkg::OP_REGISTER
         && act_q == rsv_pkg::ACT_REGISTER && !tab_if.rd_valid)
        |=> stat_q == rsv_pkg::SC_OK && tab_if.rd_valid && tab_if.rd_key == $past(new_key_field_q))
        else $error("Register did not record the host.");

    a_replace_mism: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && state_q == RSV_EVAL && supp && op_q == rsv_pkg::OP_REGISTER
         && act_q == rsv_pkg::ACT_REPLACE && !ignore_existing_key_bit_q && tab_if.rd_key != current_key_field_q)
        |=> stat_q == rsv_pkg::SC_CONFLICT)
        else $error("Replace with wrong current key accepted.");

    a_replace_force: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && state_q == RSV_EVAL && supp && op_q == rsv_pkg::OP_REGISTER
         && act_q == rsv_pkg::ACT_REPLACE && ignore_existing_key_bit_q)
        |=> tab_if.rd_valid && tab_if.rd_key == $past(new_key_field_q) && $stable(hold_q))
        else $error("Forced replace did not install the new key.");

    a_unreg_absent: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && state_q == RSV_EVAL && supp && op_q == rsv_pkg::OP_REGISTER
         && act_q == rsv_pkg::ACT_UNREG && !tab_if.rd_valid)
        |=> stat_q == rsv_pkg::SC_CONFLICT)
        else $error("Unregister of a non-registrant accepted.");

    a_ntf_masked: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && wr_acc && avs_address == rsv_pkg::OFS_NTFY && !ntf_live[ntf_ns] && !log_pend_q)
        |=> !rsv_log_avail)
        else $error("Masked notification produced a log entry.");

    a_cmd_done: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && launch) |-> ##[1:3] done_q)
        else $error("Command did not complete in time.");
endmodule
`default_nettype wire

// *** testbench/rsv_host_model.sv ***
// Host software model: an Avalon-MM master that reaches the block registers.
// Assumes one clock and a slave that answers through waitrequest.
`timescale 1ns/100ps
`default_nettype none
module rsv_host_model (
    input  wire logic        clk_sys,
    output logic      [7:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    logic hung = 1'b0;
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // Holds the request until an edge that sees waitrequest low; an edge passes after release.
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        logic w;
        int   n;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        w = 1'b1;
        n = 0;
        // Sampling right at the edge sees the values that the slave showed before it.
        while (w !== 1'b0 && !hung) begin
            @(posedge clk_sys);
            w = avs_waitrequest;
            if (w === 1'b0) q = avs_readdata;
            n++;
            if (n > 50) hung = 1'b1;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// *** testbench/namespace_reservation_registration_tb_top.sv ***
// Self-checking bench: register, replace, unregister, support and notification tests.
// Assumes the host model drives the register bus of rsv_top.
`timescale 1ns/100ps
`default_nettype none
module namespace_reservation_registration_tb_top;
    localparam logic [1:0] OK = rsv_pkg::SC_OK;
    localparam logic [1:0] CF = rsv_pkg::SC_CONFLICT;
    localparam logic [1:0] BO = rsv_pkg::SC_BAD_OPC;
    localparam logic [2:0] RG = 3'h3;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rsv_log_avail;
    int          miscompares = 0;
    int          checked = 0;
    always #20 clk_sys = !clk_sys;
    rsv_host_model host (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    rsv_top dut (.clk_sys(clk_sys), .srst(srst), .ce(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rsv_log_avail(rsv_log_avail));
    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge host.hung) begin
        miscompares++;
        report_and_stop();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        host.xfer(1'b1, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic keys(input logic [31:0] c, input logic [31:0] n);
        wr(8'h18, c);
        wr(8'h1C, ~c);
        wr(8'h20, n);
        wr(8'h24, ~n);
    endtask
    // Launches one command, polls status until done and compares the code.
    task automatic cmd(input logic [2:0] op, input logic [2:0] act, input logic ie,
                       input logic [1:0] ns, input logic [1:0] ctl, input logic [1:0] e);
        logic [31:0] q;
        wr(rsv_pkg::OFS_CMD, {21'h0, ctl, ns, ie, act, op});
        q = 32'h0;
        for (int i = 0; i < 20 && !(q[3] === 1'b1 && q[0] === 1'b0); i++) begin
            host.xfer(1'b1, rsv_pkg::OFS_STAT, 32'h0, q);
        end
        chk({29'h0, q[3:1]}, {29'h0, 1'b1, e});
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        rd(rsv_pkg::OFS_IDNS, 32'h01010101);
        rd(rsv_pkg::OFS_NSCAP, 32'h0000000F);
        wr(rsv_pkg::OFS_HOSTID, 32'hE0);
        keys(32'h0, 32'hA5);
        cmd(RG, 3'h0, 1'b1, 2'h0, 2'h0, OK);
        cmd(RG, 3'h0, 1'b0, 2'h0, 2'h1, OK);
        keys(32'h0, 32'hB6);
        cmd(RG, 3'h0, 1'b1, 2'h0, 2'h1, CF);
        keys(32'h0, 32'hA5);
        cmd(RG, 3'h0, 1'b0, 2'h0, 2'h2, OK);
        cmd(RG, 3'h5, 1'b0, 2'h0, 2'h0, rsv_pkg::SC_BAD_FIELD);
        rd(rsv_pkg::OFS_REGMAP, 32'h5);
        $display("test done: register");
        keys(32'hB6, 32'hC7);
        cmd(RG, 3'h2, 1'b0, 2'h0, 2'h1, CF);
        keys(32'hA5, 32'hC7);
        cmd(RG, 3'h2, 1'b0, 2'h0, 2'h1, OK);
        keys(32'h0, 32'hC7);
        cmd(RG, 3'h0, 1'b0, 2'h0, 2'h0, OK);
        keys(32'h0, 32'hD8);
        cmd(RG, 3'h2, 1'b1, 2'h0, 2'h3, OK);
        rd(rsv_pkg::OFS_REGMAP, 32'hD);
        wr(rsv_pkg::OFS_HOLD, 32'hB);
        cmd(3'h0, 3'h0, 1'b0, 2'h0, 2'h0, CF);
        cmd(3'h1, 3'h0, 1'b0, 2'h0, 2'h1, CF);
        cmd(3'h1, 3'h0, 1'b0, 2'h0, 2'h2, OK);
        keys(32'hA5, 32'hE9);
        cmd(RG, 3'h2, 1'b0, 2'h0, 2'h2, OK);
        rd(rsv_pkg::OFS_HOLD, 32'hB);
        keys(32'hD8, 32'h0);
        cmd(RG, 3'h1, 1'b0, 2'h0, 2'h3, OK);
        cmd(RG, 3'h1, 1'b0, 2'h0, 2'h3, CF);
        rd(rsv_pkg::OFS_REGMAP, 32'h5);
        $display("test done: replace");
        wr(rsv_pkg::OFS_CTRL, 32'h0);
        for (int op = 2; op < 6; op++) cmd(op[2:0], 3'h0, 1'b0, 2'h1, 2'h0, BO);
        rd(rsv_pkg::OFS_IDCTL, 32'h0);
        wr(rsv_pkg::OFS_CTRL, 32'h1);
        wr(rsv_pkg::OFS_NSCAP, 32'hE);
        cmd(RG, 3'h0, 1'b0, 2'h0, 2'h0, BO);
        rd(rsv_pkg::OFS_IDNS, 32'h01010100);
        $display("test done: support");
        for (int k = 1; k < 4; k++) begin
            wr(rsv_pkg::OFS_NTFY, 32'h4 | k);
            chk({31'h0, rsv_log_avail}, 32'h1);
            rd(rsv_pkg::OFS_LOG, 32'h9 | (k << 1));
            wr(rsv_pkg::OFS_NMASK, 32'h1 << (k + 2));
            wr(rsv_pkg::OFS_NTFY, 32'h4 | k);
            rd(rsv_pkg::OFS_LOG, 32'h8 | (k << 1));
            wr(rsv_pkg::OFS_NMASK, 32'h0);
        end
        $display("test done: notify");
        report_and_stop();
    end
endmodule
`default_nettype wire
